// File: emb_bus_if.sv
`timescale 1ns/1ps
module emb_bus_if #(
  parameter int CLK_DIV = 2
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // mode straps and status
  input  wire logic [2:0]                    strapSelectPins,
  output logic      [2:0]                    opMode,
  output logic                               modeProhibited,
  output logic                               standbyRelease,
  // internal request side
  input  wire logic                          reqValid,
  input  wire emb_pkg::emb_req_s             reqData,
  output logic                               reqReady,
  output logic                               rdValid,
  output logic      [emb_pkg::ADW-1:0]       rdData,
  // pin function and direction controls
  input  wire logic [emb_pkg::CMW-1:0]       busCtrlPortFunctionSelect,
  input  wire logic [emb_pkg::CMW-1:0]       busCtrlPortDirection,
  input  wire logic [emb_pkg::CTW-1:0]       strobePortFunctionSelect,
  input  wire logic [emb_pkg::CTW-1:0]       strobePortDirection,
  input  wire logic [emb_pkg::CSW-1:0]       selectPortFunctionSelect,
  input  wire logic [emb_pkg::CSW-1:0]       selectPortDirection,
  input  wire logic [emb_pkg::UAW-1:0]       upperAddrPortFunctionSelect,
  input  wire logic [emb_pkg::UAW-1:0]       upperAddrPortDirection,
  input  wire logic [emb_pkg::ADW-1:0]       addrDataPortFunctionSelect,
  input  wire logic [emb_pkg::ADW-1:0]       addrDataPortDirection,
  // port-mode output data
  input  wire logic [emb_pkg::CMW-1:0]       cmPortOut,
  input  wire logic [emb_pkg::CTW-1:0]       ctPortOut,
  input  wire logic [emb_pkg::CSW-1:0]       csPortOut,
  input  wire logic [emb_pkg::UAW-1:0]       dhPortOut,
  input  wire logic [emb_pkg::ADW-1:0]       dlPortOut,
  // pins of port cm
  input  wire logic [emb_pkg::CMW-1:0]       cmPinIn,
  output logic      [emb_pkg::CMW-1:0]       cmPinOut,
  output logic      [emb_pkg::CMW-1:0]       cmPinOe,
  // pins of port ct
  output logic      [emb_pkg::CTW-1:0]       ctPinOut,
  output logic      [emb_pkg::CTW-1:0]       ctPinOe,
  // pins of port cs
  output logic      [emb_pkg::CSW-1:0]       csPinOut,
  output logic      [emb_pkg::CSW-1:0]       csPinOe,
  // pins of port dh
  output logic      [emb_pkg::UAW-1:0]       dhPinOut,
  output logic      [emb_pkg::UAW-1:0]       dhPinOe,
  // pins of port dl
  input  wire logic [emb_pkg::ADW-1:0]       dlPinIn,
  output logic      [emb_pkg::ADW-1:0]       dlPinOut,
  output logic      [emb_pkg::ADW-1:0]       dlPinOe
);

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ADDR   = 6'h02,
    ST_DATA   = 6'h04,
    ST_STALL  = 6'h08,
    ST_FINISH = 6'h10,
    ST_HOLD   = 6'h20
  } emb_state_e;

  emb_state_e              state_reg;
  emb_state_e              state_next;
  emb_pkg::emb_req_s       req_reg;
  logic [7:0]              divCnt_reg;
  logic                    system_clock_output_reg;
  logic                    strapLatch_reg;
  logic [2:0]              mode_reg;
  logic [emb_pkg::CMW-1:0] cmFunc_reg;
  logic                    lowWr_reg;
  logic                    highWr_reg;
  logic                    rd_reg;
  logic                    address_latch_strobe_reg;
  logic                    grant_reg;
  logic [emb_pkg::CSW-1:0] sel_reg;
  logic [emb_pkg::ADW-1:0] ad_reg;
  logic                    adDrive_reg;

  // ****************************************************************
  // synchronisers for asynchronous pins
  // ****************************************************************
  logic [emb_pkg::CMW-1:0] cmSync;
  logic [emb_pkg::ADW-1:0] dlSync;

  emb_sync2 #(.W(emb_pkg::CMW)) u_cmSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (cmPinIn),
    .syncOut (cmSync)
  );

  emb_sync2 #(.W(emb_pkg::ADW)) u_dlSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (dlPinIn),
    .syncOut (dlSync)
  );

  // ****************************************************************
  // clock output divider and edge decode
  // ****************************************************************
  wire lastDiv  = (divCnt_reg == 8'(CLK_DIV - 1));
  wire fallTick = lastDiv & system_clock_output_reg;
  wire riseTick = lastDiv & ~system_clock_output_reg;
  wire holdReq  = cmSync[emb_pkg::CM_HOLDRQ]
                & cmFunc_reg[emb_pkg::CM_HOLDRQ];
  wire stallReq = cmSync[emb_pkg::CM_STALL] & cmFunc_reg[emb_pkg::CM_STALL];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_reg <= 8'h00;
      system_clock_output_reg <= 1'b0;
    end else begin
      divCnt_reg <= lastDiv ? 8'h00 : divCnt_reg + 8'h01;
      system_clock_output_reg <= lastDiv ? ~system_clock_output_reg : system_clock_output_reg;
    end
  end

  // ****************************************************************
  // strap capture after reset release
  // ****************************************************************
  logic [2:0] strapMeta_reg;
  logic [2:0] strapSync_reg;

  // straps settle through two flops while reset is held
  always_ff @(posedge clk_sys) begin
    strapMeta_reg <= strapSelectPins;
    strapSync_reg <= strapMeta_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strapLatch_reg <= 1'b0;
      mode_reg       <= emb_pkg::STRAP_ROMLESS0;
    end else if (!strapLatch_reg) begin
      strapLatch_reg <= 1'b1;
      mode_reg       <= strapSync_reg;
    end
  end

  wire modeBad = (mode_reg > emb_pkg::STRAP_SINGLE1);

  // clock pin starts in bus use only in single-chip mode 0
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmFunc_reg <= emb_pkg::CM_FUNC_RST;
    end else if (!strapLatch_reg) begin
      cmFunc_reg <= (strapSync_reg == emb_pkg::STRAP_SINGLE0) ?
                    emb_pkg::CM_FUNC_SC0 : emb_pkg::CM_FUNC_RST;
    end else begin
      cmFunc_reg <= busCtrlPortFunctionSelect;
    end
  end

  // ****************************************************************
  // bus cycle sequencer, steps on the falling edge of clock output
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (holdReq) begin
          state_next = ST_HOLD;
        end else if (reqValid && !modeBad) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR:   state_next = ST_DATA;
      ST_DATA:   state_next = stallReq ? ST_STALL : ST_FINISH;
      ST_STALL:  state_next = stallReq ? ST_STALL : ST_FINISH;
      ST_FINISH: state_next = ST_IDLE;
      ST_HOLD:   state_next = holdReq ? ST_HOLD : ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      req_reg   <= '0;
    end else if (fallTick) begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next == ST_ADDR) begin
        req_reg <= reqData;
      end
    end
  end

  // ****************************************************************
  // strobes and bus values, registered at falling edges
  // ****************************************************************
  wire enterAddr = fallTick & (state_next == ST_ADDR) & (state_reg == ST_IDLE);
  wire inAddr    = fallTick & (state_reg == ST_ADDR);
  wire inData    = fallTick & (state_reg == ST_DATA);
  wire inFinish  = fallTick & (state_reg == ST_FINISH);
  wire cycleEnd  = fallTick & (state_reg == ST_FINISH);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowWr_reg   <= 1'b1;
      highWr_reg  <= 1'b1;
      rd_reg      <= 1'b1;
      address_latch_strobe_reg    <= 1'b1;
      sel_reg     <= '1;
      ad_reg      <= emb_pkg::FUNC_RST16;
      adDrive_reg <= 1'b0;
    end else begin
      if (enterAddr) begin
        address_latch_strobe_reg    <= 1'b0;
        lowWr_reg   <= ~(reqData.write & reqData.laneEn[0]);
        highWr_reg  <= ~(reqData.write & reqData.laneEn[1]);
        rd_reg      <= reqData.write;
        sel_reg     <= ~(8'h01 << reqData.block);
        ad_reg      <= reqData.addr[15:0];
        adDrive_reg <= 1'b1;
      end else if (inAddr) begin
        ad_reg      <= req_reg.wdata;
        adDrive_reg <= req_reg.write;
      end else if (inData) begin
        lowWr_reg   <= 1'b1;
        highWr_reg  <= 1'b1;
      end else if (inFinish) begin
        address_latch_strobe_reg    <= 1'b1;
        rd_reg      <= 1'b1;
        sel_reg     <= '1;
        adDrive_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // hold grant and handshake outputs
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      grant_reg     <= 1'b0;
      reqReady      <= 1'b0;
      rdValid       <= 1'b0;
      rdData        <= emb_pkg::FUNC_RST16;
      opMode        <= emb_pkg::STRAP_ROMLESS0;
      modeProhibited <= 1'b0;
      standbyRelease <= 1'b1;
    end else begin
      grant_reg      <= (state_reg == ST_HOLD);
      reqReady       <= enterAddr;
      rdValid        <= cycleEnd & ~req_reg.write;
      rdData         <= (cycleEnd & ~req_reg.write) ? dlSync : rdData;
      opMode         <= mode_reg;
      modeProhibited <= strapLatch_reg & modeBad;
      standbyRelease <= 1'b0;
    end
  end

  // ****************************************************************
  // pin multiplexing: bus function or port, per bit
  // ****************************************************************
  logic [emb_pkg::CMW-1:0] cmBusOut;
  logic [emb_pkg::CMW-1:0] cmBusOe;
  logic [emb_pkg::CTW-1:0] ctBusOut;
  logic [emb_pkg::CTW-1:0] ctBusOe;

  wire busOwned = ~grant_reg;

  always_comb begin
    cmBusOut = '0;
    cmBusOe  = '0;
    cmBusOut[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT] = system_clock_output_reg;
    cmBusOe[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT]  = 1'b1;
    cmBusOut[emb_pkg::CM_GRANT]  = ~grant_reg; // grant pin is active low
    cmBusOe[emb_pkg::CM_GRANT]   = 1'b1;
    ctBusOut = '0;
    ctBusOe  = '0;
    ctBusOut[emb_pkg::CT_LOW_WR]  = lowWr_reg;
    ctBusOut[emb_pkg::CT_HIGH_WR] = highWr_reg;
    ctBusOut[emb_pkg::CT_RD]      = rd_reg;
    ctBusOut[emb_pkg::CT_ADDRESS_LATCH_STROBE]    = address_latch_strobe_reg;
    ctBusOe[emb_pkg::CT_LOW_WR]   = busOwned;
    ctBusOe[emb_pkg::CT_HIGH_WR]  = busOwned;
    ctBusOe[emb_pkg::CT_RD]       = busOwned;
    ctBusOe[emb_pkg::CT_ADDRESS_LATCH_STROBE]     = busOwned;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmPinOut <= '0;
      cmPinOe  <= '0;
      ctPinOut <= '0;
      ctPinOe  <= '0;
      csPinOut <= '0;
      csPinOe  <= '0;
      dhPinOut <= '0;
      dhPinOe  <= '0;
      dlPinOut <= '0;
      dlPinOe  <= '0;
    end else begin
      cmPinOut <= (cmFunc_reg & cmBusOut) | (~cmFunc_reg & cmPortOut);
      cmPinOe  <= (cmFunc_reg & cmBusOe) | (~cmFunc_reg & busCtrlPortDirection);
      ctPinOut <= (strobePortFunctionSelect & ctBusOut)
                | (~strobePortFunctionSelect & ctPortOut);
      ctPinOe  <= (strobePortFunctionSelect & ctBusOe)
                | (~strobePortFunctionSelect & strobePortDirection);
      csPinOut <= (selectPortFunctionSelect & sel_reg)
                | (~selectPortFunctionSelect & csPortOut);
      csPinOe  <= (selectPortFunctionSelect & {emb_pkg::CSW{busOwned}})
                | (~selectPortFunctionSelect & selectPortDirection);
      dhPinOut <= (upperAddrPortFunctionSelect & req_reg.addr[23:16])
                | (~upperAddrPortFunctionSelect & dhPortOut);
      dhPinOe  <= (upperAddrPortFunctionSelect & {emb_pkg::UAW{busOwned}})
                | (~upperAddrPortFunctionSelect & upperAddrPortDirection);
      dlPinOut <= (addrDataPortFunctionSelect & ad_reg)
                | (~addrDataPortFunctionSelect & dlPortOut);
      dlPinOe  <= (addrDataPortFunctionSelect & {emb_pkg::ADW{busOwned & adDrive_reg}})
                | (~addrDataPortFunctionSelect & addrDataPortDirection);
    end
  end

endmodule // emb_bus_if

// File: emb_pkg.sv
package emb_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADW      = 16;
  localparam int UAW      = 8;
  localparam int CSW      = 8;
  localparam int CTW      = 8;
  localparam int CMW      = 5;

  // ****************************************************************
  // pin positions inside the strobe and bus-control ports
  // ****************************************************************
  localparam int CT_LOW_WR  = 0;
  localparam int CT_HIGH_WR = 1;
  localparam int CT_RD      = 4;
  localparam int CT_ADDRESS_LATCH_STROBE    = 6;
  localparam int CM_STALL   = 0;
  localparam int CM_SYSTEM_CLOCK_OUTPUT  = 1;
  localparam int CM_GRANT   = 2;
  localparam int CM_HOLDRQ  = 3;

  // ****************************************************************
  // reset values and strap codes
  // ****************************************************************
  localparam logic [ADW-1:0] FUNC_RST16 = 16'h0000;
  localparam logic [7:0]     FUNC_RST8  = 8'h00;
  localparam logic [CMW-1:0] CM_FUNC_RST = 5'h00;
  localparam logic [CMW-1:0] CM_FUNC_SC0 = 5'h02;
  localparam logic [2:0] STRAP_ROMLESS0 = 3'h0;
  localparam logic [2:0] STRAP_ROMLESS1 = 3'h1;
  localparam logic [2:0] STRAP_SINGLE0  = 3'h2;
  localparam logic [2:0] STRAP_SINGLE1  = 3'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_ROMLESS0 = 3'h0,
    MODE_ROMLESS1 = 3'h1,
    MODE_SINGLE0  = 3'h2,
    MODE_SINGLE1  = 3'h3,
    MODE_BAD      = 3'h7
  } emb_mode_e;

  typedef struct packed {
    logic        write;
    logic [1:0]  laneEn;
    logic [2:0]  block;
    logic [23:0] addr;
    logic [15:0] wdata;
  } emb_req_s;

endpackage

// File: emb_sync2.sv
`timescale 1ns/1ps
module emb_sync2 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule // emb_sync2

// File: emb_bus_if_chk.sv
`timescale 1ns/1ps
module emb_bus_if_chk #(
  parameter int CLK_DIV = 2
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // controls
  input wire logic [4:0]  busCtrlPortFunctionSelect,
  input wire logic [7:0]  strobePortFunctionSelect,
  input wire logic [7:0]  ctPortOut,
  input wire logic [15:0] addrDataPortFunctionSelect,
  input wire logic [15:0] addrDataPortDirection,
  // pins
  input wire logic [4:0]  cmPinIn,
  input wire logic [4:0]  cmPinOut,
  input wire logic [4:0]  cmPinOe,
  input wire logic [7:0]  ctPinOut,
  input wire logic [7:0]  ctPinOe,
  input wire logic [7:0]  csPinOut,
  input wire logic [15:0] dlPinOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic ctBus;

  // strobe pins follow the function selects one clock later
  always_ff @(posedge clk_sys) begin
    ctBus <= rst ? 1'b0 : &strobePortFunctionSelect;
  end

  wire astbN   = ctPinOut[emb_pkg::CT_ADDRESS_LATCH_STROBE];
  wire lwrN    = ctPinOut[emb_pkg::CT_LOW_WR];
  wire hwrN    = ctPinOut[emb_pkg::CT_HIGH_WR];
  wire rdN     = ctPinOut[emb_pkg::CT_RD];
  wire holdReq = cmPinIn[emb_pkg::CM_HOLDRQ];
  wire grantN  = cmPinOut[emb_pkg::CM_GRANT];
  wire grantOn = cmPinOe[emb_pkg::CM_GRANT] && !grantN;

  // ****************************************************************
  // strobe shapes
  // ****************************************************************
  // a write strobe spans two clock-output periods
  sequence s_wrPulse(s);
    (!s)[*8] ##1 s;
  endsequence
  sequence s_astbSpan;
    (!astbN)[*8] ##[5:400] $rose(astbN);
  endsequence

  property p_low_wr;
    ctBus && $fell(lwrN) |-> s_wrPulse(lwrN);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low write strobe width wrong");
  property p_high_wr;
    ctBus && $fell(hwrN) |-> s_wrPulse(hwrN);
  endproperty
  a_high_wr: assert property (p_high_wr) else $error("high write strobe width wrong");
  property p_read_only;
    ctBus && !rdN |-> !astbN && lwrN && hwrN;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read strobe outside read");
  property p_select_one;
    ctBus && $fell(astbN) |-> $onehot(~csPinOut) && (&dlPinOe);
  endproperty
  a_select_one: assert property (p_select_one) else $error("select or address bad");
  property p_select_idle;
    ctBus && $rose(astbN) |-> &csPinOut;
  endproperty
  a_select_idle: assert property (p_select_idle) else $error("select held in idle");
  property p_address_latch_strobe_span;
    ctBus && $fell(astbN) |-> s_astbSpan;
  endproperty
  a_address_latch_strobe_span: assert property (p_address_latch_strobe_span) else $error("latch strobe span wrong");

  // ****************************************************************
  // hold and port use
  // ****************************************************************
  property p_hold_float;
    grantOn |-> (dlPinOe == 16'h0000) && ((ctPinOe & 8'h53) == 8'h00);
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("bus driven under grant");
  property p_grant_req;
    !$past(rst) && $fell(grantN) |-> $past(holdReq, 2);
  endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
  property p_grant_drop;
    !$past(rst) && $rose(grantN) |-> !$past(holdReq, 2);
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant dropped early");
  property p_port_pins;
    !$past(rst) |->
      ((dlPinOe & ~$past(addrDataPortFunctionSelect)) ==
       ($past(addrDataPortDirection) & ~$past(addrDataPortFunctionSelect))) &&
      ((ctPinOut & ~$past(strobePortFunctionSelect)) ==
       ($past(ctPortOut) & ~$past(strobePortFunctionSelect)));
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port use pin mismatch");
endmodule // emb_bus_if_chk

bind emb_bus_if emb_bus_if_chk #(.CLK_DIV(CLK_DIV)) u_chk (.clk_sys, .rst,
  .busCtrlPortFunctionSelect, .strobePortFunctionSelect, .ctPortOut,
  .addrDataPortFunctionSelect, .addrDataPortDirection, .cmPinIn, .cmPinOut, .cmPinOe,
  .ctPinOut, .ctPinOe, .csPinOut, .dlPinOe);

// File: emb_mem_model.sv
`timescale 1ns/1ps
module emb_mem_model (
  // clock and pacing
  input  wire logic        clk_sys,
  input  wire logic        slow,
  // device pins
  input  wire logic [7:0]  ctPinOut,
  input  wire logic [7:0]  csPinOut,
  input  wire logic [7:0]  dhPinOut,
  input  wire logic [15:0] dlPinOut,
  // answers
  output logic      [15:0] drive,
  output logic             stall,
  output logic      [7:0]  seenUpper,
  output logic      [7:0]  seenSelN
);
  logic [15:0] mem [16];
  logic [3:0]  slot;
  logic [7:0]  ctPrev = 8'hFF;
  int          stallCnt = 0;

  initial drive = 16'h0000;
  initial stall = 1'b0;
  // released lines toggle so a stale value never looks valid
  always @(posedge clk_sys) begin
    ctPrev <= ctPinOut;
    stall <= (stallCnt > 0);
    if (stallCnt > 0) stallCnt <= stallCnt - 1;
    if (ctPrev[emb_pkg::CT_ADDRESS_LATCH_STROBE] && !ctPinOut[emb_pkg::CT_ADDRESS_LATCH_STROBE]) begin
      slot <= dlPinOut[3:0];
      seenUpper <= dhPinOut;
      seenSelN <= csPinOut;
      if (slow) stallCnt <= 20;
    end
    if (!ctPrev[emb_pkg::CT_LOW_WR] && ctPinOut[emb_pkg::CT_LOW_WR])
      mem[slot][7:0] <= dlPinOut[7:0];
    if (!ctPrev[emb_pkg::CT_HIGH_WR] && ctPinOut[emb_pkg::CT_HIGH_WR])
      mem[slot][15:8] <= dlPinOut[15:8];
    drive <= ctPinOut[emb_pkg::CT_RD] ? ~drive : mem[slot];
  end
endmodule // emb_mem_model

// File: emb_bus_if_tb_top.sv
`timescale 1ns/1ps
module emb_bus_if_tb_top;
  logic clk_sys, rst, linkClk, reqValid, reqReady, rdValid, modeProhibited, standbyRelease;
  logic holdReq, slow, stall;
  logic [2:0] strapSelectPins, opMode;
  emb_pkg::emb_req_s reqData;
  logic [4:0] busCtrlPortFunctionSelect, busCtrlPortDirection, cmPortOut;
  logic [4:0] cmPinIn, cmPinOut, cmPinOe;
  logic [7:0] strobePortFunctionSelect, strobePortDirection, ctPortOut, ctPinOut, ctPinOe;
  logic [7:0] selectPortFunctionSelect, selectPortDirection, csPortOut, csPinOut, csPinOe;
  logic [7:0] upperAddrPortFunctionSelect, upperAddrPortDirection, dhPortOut, dhPinOut, dhPinOe;
  logic [7:0] seenUpper, seenSelN;
  logic [15:0] addrDataPortFunctionSelect, addrDataPortDirection, dlPortOut, dlPinIn, dlPinOut;
  logic [15:0] dlPinOe, rdData, memDrive;
  int fail_count, total_checks;

  assign dlPinIn = (dlPinOe & dlPinOut) | (~dlPinOe & memDrive);
  assign cmPinIn = {1'b0, holdReq, cmPinOut[2:1], stall};
  wire grantOn = cmPinOe[emb_pkg::CM_GRANT] && (cmPinOut[emb_pkg::CM_GRANT] === 1'b0);

  emb_bus_if #(.CLK_DIV(2)) uut (.clk_sys, .rst, .strapSelectPins, .opMode, .modeProhibited,
    .standbyRelease, .reqValid, .reqData, .reqReady, .rdValid, .rdData,
    .busCtrlPortFunctionSelect, .busCtrlPortDirection, .strobePortFunctionSelect,
    .strobePortDirection, .selectPortFunctionSelect, .selectPortDirection,
    .upperAddrPortFunctionSelect, .upperAddrPortDirection, .addrDataPortFunctionSelect,
    .addrDataPortDirection, .cmPortOut, .ctPortOut, .csPortOut, .dhPortOut, .dlPortOut,
    .cmPinIn, .cmPinOut, .cmPinOe, .ctPinOut, .ctPinOe, .csPinOut, .csPinOe, .dhPinOut,
    .dhPinOe, .dlPinIn, .dlPinOut, .dlPinOe);
  emb_mem_model mem (.clk_sys, .slow, .ctPinOut, .csPinOut, .dhPinOut, .dlPinOut,
    .drive(memDrive), .stall, .seenUpper, .seenSelN);

  // ****************************************************************
  // clocks, watchdog, tasks
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    linkClk = 1'b0;
    forever #80 linkClk = ~linkClk;
  end
  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    strapSelectPins = s;
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    chk(24'({standbyRelease, dlPinOe}), 24'h010000);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(24'(standbyRelease), 24'h000000);
  endtask
  task automatic count_clk(output int n);
    logic p;
    p = cmPinOut[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT];
    n = 0;
    repeat (16) begin
      @(negedge clk_sys);
      if (cmPinOut[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT] !== p) n++;
      p = cmPinOut[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT];
    end
  endtask
  task automatic bus_op(input logic wr, input logic [1:0] ln, input logic [2:0] blk,
                        input logic [23:0] a, input logic [15:0] d, output int w, output int l);
    w = 0;
    l = 0;
    @(negedge clk_sys);
    reqData = '{wr, ln, blk, a, d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && w < 300) begin
      @(negedge clk_sys);
      w++;
    end
    reqValid = 1'b0;
    while (!wr && rdValid !== 1'b1 && l < 300) begin
      @(negedge clk_sys);
      l++;
    end
    if (w >= 300 || l >= 300) begin
      fail_count++;
      $display("Error at %0t: no answer", $time);
    end
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    int w, l, latF, latS, n;
    logic [15:0] exp;
    {fail_count, total_checks, reqValid, holdReq, slow} = '0;
    reqData = '0;
    {busCtrlPortFunctionSelect, strobePortFunctionSelect, selectPortFunctionSelect,
     upperAddrPortFunctionSelect, addrDataPortFunctionSelect} = '0;
    {busCtrlPortDirection, strobePortDirection, selectPortDirection, upperAddrPortDirection,
     addrDataPortDirection} = {5'h00, 8'h3C, 8'h0F, 8'hF0, 16'h0FF0};
    {cmPortOut, ctPortOut, csPortOut, dhPortOut, dlPortOut} =
      {5'h0A, 8'hC3, 8'h96, 8'h69, 16'hA55A};
    do_reset(emb_pkg::STRAP_ROMLESS0);
    chk(24'({dlPinOe, dlPinOut & 16'h0FF0}), 24'hF00550);
    chk({ctPinOe, csPinOe, dhPinOe}, 24'h3C0FF0);
    count_clk(n);
    chk(24'({cmPinOe[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT], 8'(n)}), 24'h000);
    {busCtrlPortFunctionSelect, strobePortFunctionSelect, selectPortFunctionSelect,
     upperAddrPortFunctionSelect, addrDataPortFunctionSelect} = '1;
    repeat (2) @(negedge clk_sys);
    count_clk(n);
    chk(24'({cmPinOe[emb_pkg::CM_SYSTEM_CLOCK_OUTPUT], 8'(n)}), 24'h108);
    for (int i = 0; i < 8; i++)
      bus_op(1'b1, 2'b11, 3'(i), {5'h18, 3'(i), 13'h0, 3'(i)},
             {8'h80 + 8'(i), 8'h10 + 8'(i)}, w, l);
    bus_op(1'b1, 2'b01, 3'd0, {5'h18, 3'd0, 16'h0000}, 16'hFFFF, w, l);
    bus_op(1'b1, 2'b10, 3'd1, {5'h18, 3'd1, 16'h0001}, 16'h0000, w, l);
    for (int i = 0; i < 8; i++) begin
      bus_op(1'b0, 2'b11, 3'(i), {5'h18, 3'(i), 13'h0, 3'(i)}, 16'h0000, w, latF);
      exp = (i == 0) ? 16'h80FF : (i == 1) ? 16'h0011 : {8'h80 + 8'(i), 8'h10 + 8'(i)};
      chk(24'(rdData), 24'(exp));
      chk(24'({seenUpper, seenSelN}), 24'({5'h18, 3'(i), ~(8'h01 << i)}));
    end
    slow = 1'b1;
    bus_op(1'b0, 2'b11, 3'd2, {5'h18, 3'd2, 16'h0002}, 16'h0000, w, latS);
    slow = 1'b0;
    chk(24'(rdData), 24'h8212);
    chk(24'({(latS - latF) % 4 == 0, latS > latF + 3}), 24'h3);
    @(posedge linkClk);
    @(negedge clk_sys);
    holdReq = 1'b1;
    n = 0;
    // request stays up until the grant shows
    while (!grantOn && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(24'(n < 100), 24'h1);
    chk(24'({ctPinOe & 8'h53, dlPinOe}), 24'h0);
    fork
      bus_op(1'b0, 2'b11, 3'd3, {5'h18, 3'd3, 16'h0003}, 16'h0000, w, l);
      begin
        repeat (40) @(negedge clk_sys);
        holdReq = 1'b0;
      end
    join
    chk(24'({w > 40, rdData}), 24'h18313);
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
      chk(24'({modeProhibited, (c < 4) ? opMode : 3'(c)}), 24'({c > 3, 3'(c)}));
    end
    tally_and_finish();
  end
endmodule // emb_bus_if_tb_top
